// [hdl/drdt_map.svh]
/*
 Register offsets, field positions and reset values of the dual reload down timer.
 Offsets are register indices; the APB byte address is four times the index.
*/
`ifndef DRDT_MAP_SVH
`define DRDT_MAP_SVH
`define DRDT_IDX_MODE 16'hFFC0
`define DRDT_IDX_CLKSRC 16'hFFC1
`define DRDT_IDX_T0CTL 16'hFFC2
`define DRDT_IDX_T1CTL 16'hFFC3
`define DRDT_IDX_T0RLL 16'hFFC4
`define DRDT_IDX_T0RLH 16'hFFC5
`define DRDT_IDX_T1RLL 16'hFFC6
`define DRDT_IDX_T1RLH 16'hFFC7
`define DRDT_IDX_T0CNL 16'hFFC8
`define DRDT_IDX_T0CNH 16'hFFC9
`define DRDT_IDX_T1CNL 16'hFFCA
`define DRDT_IDX_T1CNH 16'hFFCB
`define DRDT_IDX_IEN 16'hFFE2
`define DRDT_IDX_IFLG 16'hFFF2
`define DRDT_BIT_POL 0
`define DRDT_BIT_NF 1
`define DRDT_BIT_EVT 2
`define DRDT_BIT_CHAIN 3
`define DRDT_BIT_RUN 0
`define DRDT_BIT_STB 1
`define DRDT_RST_NIB 4'h0
`define DRDT_RST_BYTE 8'h00
`define DRDT_DIV4_M1 8'h03
`define DRDT_DIV32_M1 8'h1F
`define DRDT_DIV256_M1 8'hFF
`endif

// [hdl/drdt_pkg.sv]
/*
 Types of the dual reload down timer.
 Assumes nothing beyond the map header.
*/
`default_nettype none
package drdt_pkg;
  typedef enum logic [1:0] {
    DRDT_DIV1 = 2'b00,
    DRDT_DIV4 = 2'b01,
    DRDT_DIV32 = 2'b10,
    DRDT_DIV256 = 2'b11
  } drdt_div_t;
endpackage : drdt_pkg
`default_nettype wire

// [hdl/drdt_timer.sv]
/*
 Dual 8-bit reload down timer with APB register slave.
 Assumes oscillator clocks, tick and count pin are asynchronous and slower than mclk/2.
*/
`default_nettype none
`include "drdt_map.svh"
module drdt_timer
  import drdt_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_oscillator_clock,
  input wire logic fast_oscillator_clock,
  input wire logic tick_2048hz,
  input wire logic event_count_pin,
  output logic t0_irq_req,
  output logic t1_irq_req
);
  logic [3:0] mode_reg;
  logic [1:0] src_reg;
  logic [1:0] t0_ratio_reg, t1_ratio_reg;
  logic t0_run_reg, t1_run_reg;
  logic [7:0] t0_reload_value, t1_reload_value;
  logic [7:0] t0_count_value, t1_count_value;
  logic [3:0] t0_hi_latch_reg, t1_hi_latch_reg;
  logic [1:0] irq_en_reg, irq_flag_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  logic t0_irq_reg, t1_irq_reg;

  // Two-stage synchronisers; no reset, so they track the pins and give no false edge at release
  logic [3:0] sync1_reg, sync2_reg, prev_reg;
  always_ff @(posedge mclk) begin
    sync1_reg <= {event_count_pin, tick_2048hz, fast_oscillator_clock, slow_oscillator_clock};
    sync2_reg <= sync1_reg;
    prev_reg <= sync2_reg;
  end
  wire [3:0] fall = prev_reg & ~sync2_reg;
  wire [3:0] rise = ~prev_reg & sync2_reg;
  wire tick_fall = fall[2];

  // Noise rejecter: second tick fall after change
  logic filt_reg;
  logic [1:0] ftick_reg;
  wire pin_now = sync2_reg[3];
  always_ff @(posedge mclk) begin
    if (reset) begin
      filt_reg <= pin_now; // Start at the pin level: no spurious edge
      ftick_reg <= 2'b00;
    end else if (pin_now == filt_reg) begin
      ftick_reg <= 2'b00;
    end else if (tick_fall) begin
      if (ftick_reg == 2'b01) begin
        filt_reg <= pin_now;
        ftick_reg <= 2'b00;
      end else begin
        ftick_reg <= ftick_reg + 2'b01;
      end
    end
  end
  logic filt_prev_reg;
  always_ff @(posedge mclk) begin
    if (reset) filt_prev_reg <= pin_now;
    else filt_prev_reg <= filt_reg;
  end
  wire pin_fall = mode_reg[`DRDT_BIT_NF] ? (filt_prev_reg & ~filt_reg) : fall[3];
  wire pin_rise = mode_reg[`DRDT_BIT_NF] ? (~filt_prev_reg & filt_reg) : rise[3];
  wire evt_edge = mode_reg[`DRDT_BIT_POL] ? pin_rise : pin_fall;

  // Prescalers
  function automatic logic [7:0] div_last(input logic [1:0] r);
    case (r)
      DRDT_DIV256: div_last = `DRDT_DIV256_M1;
      DRDT_DIV32: div_last = `DRDT_DIV32_M1;
      DRDT_DIV4: div_last = `DRDT_DIV4_M1;
      default: div_last = `DRDT_RST_BYTE;
    endcase
  endfunction : div_last
  wire t0_src_fall = src_reg[0] ? fall[1] : fall[0];
  wire t1_src_fall = src_reg[1] ? fall[1] : fall[0];
  logic [7:0] p0_reg, p1_reg;
  wire p0_hit = t0_src_fall && (p0_reg >= div_last(t0_ratio_reg));
  wire p1_hit = t1_src_fall && (p1_reg >= div_last(t1_ratio_reg));
  always_ff @(posedge mclk) begin
    if (reset) begin
      p0_reg <= `DRDT_RST_BYTE;
      p1_reg <= `DRDT_RST_BYTE;
    end else begin
      if (t0_src_fall) p0_reg <= p0_hit ? `DRDT_RST_BYTE : p0_reg + 8'h01;
      if (t1_src_fall) p1_reg <= p1_hit ? `DRDT_RST_BYTE : p1_reg + 8'h01;
    end
  end

  wire chain = mode_reg[`DRDT_BIT_CHAIN];
  wire t0_tick = mode_reg[`DRDT_BIT_EVT] ? evt_edge : p0_hit;
  wire t0_dec = t0_tick && t0_run_reg;
  wire t0_under = t0_dec && (t0_count_value == 8'h00);
  wire t1_tick = chain ? t0_under : p1_hit;
  wire t1_dec = t1_tick && t1_run_reg;
  wire t1_under = t1_dec && (t1_count_value == 8'h00);

  // APB decode; pready one cycle into the access phase
  wire acc = psel && penable && !pready_reg;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  // Offsets are register indices: byte address is index times four
  wire [15:0] ra = paddr[17:2];
  wire aligned = (paddr[1:0] == 2'b00) && (paddr[31:18] == 14'h0000);
  wire hit_mode = aligned && ra == `DRDT_IDX_MODE;
  wire hit_src = aligned && ra == `DRDT_IDX_CLKSRC;
  wire hit_t0c = aligned && ra == `DRDT_IDX_T0CTL;
  wire hit_t1c = aligned && ra == `DRDT_IDX_T1CTL;
  wire hit_ien = aligned && ra == `DRDT_IDX_IEN;
  wire hit_ifl = aligned && ra == `DRDT_IDX_IFLG;
  wire hit_t0cl = aligned && ra == `DRDT_IDX_T0CNL;
  wire hit_t1cl = aligned && ra == `DRDT_IDX_T1CNL;
  wire [3:0] wn = pwdata[3:0];
  wire t0_strobe = wr && hit_t0c && wn[`DRDT_BIT_STB];
  wire t1_strobe = wr && hit_t1c && wn[`DRDT_BIT_STB];

  always_ff @(posedge mclk) begin
    if (reset) begin
      mode_reg <= `DRDT_RST_NIB;
      src_reg <= 2'b00;
      t0_ratio_reg <= 2'b00;
      t1_ratio_reg <= 2'b00;
      t0_run_reg <= 1'b0;
      t1_run_reg <= 1'b0;
      t0_reload_value <= `DRDT_RST_BYTE;
      t1_reload_value <= `DRDT_RST_BYTE;
      irq_en_reg <= 2'b00;
    end else if (wr) begin
      if (hit_mode) mode_reg <= wn;
      if (hit_src) src_reg <= wn[1:0];
      if (hit_t0c) begin
        t0_run_reg <= wn[`DRDT_BIT_RUN];
        t0_ratio_reg <= wn[3:2];
      end
      if (hit_t1c) begin
        t1_run_reg <= wn[`DRDT_BIT_RUN];
        t1_ratio_reg <= wn[3:2];
      end
      if (aligned && ra == `DRDT_IDX_T0RLL) t0_reload_value[3:0] <= wn;
      if (aligned && ra == `DRDT_IDX_T0RLH) t0_reload_value[7:4] <= wn;
      if (aligned && ra == `DRDT_IDX_T1RLL) t1_reload_value[3:0] <= wn;
      if (aligned && ra == `DRDT_IDX_T1RLH) t1_reload_value[7:4] <= wn;
      if (hit_ien) irq_en_reg <= wn[1:0];
    end
  end

  // Counters; strobe presets regardless of run state
  always_ff @(posedge mclk) begin
    if (reset) begin
      t0_count_value <= `DRDT_RST_BYTE;
      t1_count_value <= `DRDT_RST_BYTE;
    end else begin
      if (t0_strobe || t0_under) t0_count_value <= t0_reload_value;
      else if (t0_dec) t0_count_value <= t0_count_value - 8'h01;
      if (t1_strobe || t1_under) t1_count_value <= t1_reload_value;
      else if (t1_dec) t1_count_value <= t1_count_value - 8'h01;
    end
  end

  // Flags: hardware set wins over software clear
  wire t0_flag_set = t0_under && !chain;
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_flag_reg <= 2'b00;
    end else begin
      irq_flag_reg[0] <= t0_flag_set | (irq_flag_reg[0] & ~(wr && hit_ifl && wn[0]));
      irq_flag_reg[1] <= t1_under | (irq_flag_reg[1] & ~(wr && hit_ifl && wn[1]));
    end
  end

  // High nibble latches, captured on low nibble read
  always_ff @(posedge mclk) begin
    if (reset) begin
      t0_hi_latch_reg <= `DRDT_RST_NIB;
      t1_hi_latch_reg <= `DRDT_RST_NIB;
    end else begin
      if (rd && hit_t0cl) t0_hi_latch_reg <= t0_count_value[7:4];
      if (rd && hit_t1cl) t1_hi_latch_reg <= t1_count_value[7:4];
    end
  end

  logic [3:0] rnib;
  logic rmapped;
  always_comb begin
    rnib = 4'h0;
    rmapped = 1'b1;
    case (ra)
      `DRDT_IDX_MODE: rnib = mode_reg;
      `DRDT_IDX_CLKSRC: rnib = {2'b00, src_reg};
      `DRDT_IDX_T0CTL: rnib = {t0_ratio_reg, 1'b0, t0_run_reg};
      `DRDT_IDX_T1CTL: rnib = {t1_ratio_reg, 1'b0, t1_run_reg};
      `DRDT_IDX_T0RLL: rnib = t0_reload_value[3:0];
      `DRDT_IDX_T0RLH: rnib = t0_reload_value[7:4];
      `DRDT_IDX_T1RLL: rnib = t1_reload_value[3:0];
      `DRDT_IDX_T1RLH: rnib = t1_reload_value[7:4];
      `DRDT_IDX_T0CNL: rnib = t0_count_value[3:0];
      `DRDT_IDX_T0CNH: rnib = t0_hi_latch_reg;
      `DRDT_IDX_T1CNL: rnib = t1_count_value[3:0];
      `DRDT_IDX_T1CNH: rnib = t1_hi_latch_reg;
      `DRDT_IDX_IEN: rnib = {2'b00, irq_en_reg};
      `DRDT_IDX_IFLG: rnib = {2'b00, irq_flag_reg};
      default: rmapped = 1'b0;
    endcase
    if (!aligned) rmapped = 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      t0_irq_reg <= 1'b0;
      t1_irq_reg <= 1'b0;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      pslverr_reg <= acc && !rmapped;
      if (rd) prdata_reg <= {28'h0000000, rmapped ? rnib : 4'h0};
      t0_irq_reg <= irq_flag_reg[0] & irq_en_reg[0];
      t1_irq_reg <= irq_flag_reg[1] & irq_en_reg[1];
    end
  end
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign t0_irq_req = t0_irq_reg;
  assign t1_irq_req = t1_irq_reg;

  property p_strobe_load;
    @(posedge mclk) disable iff (reset) t0_strobe |=> t0_count_value == $past(t0_reload_value);
  endproperty
  a_strobe_load: assert property (p_strobe_load) else $error("strobe did not preset");
  property p_hold_stop;
    @(posedge mclk) disable iff (reset) (!t0_run_reg && !t0_strobe) |=> $stable(t0_count_value);
  endproperty
  a_hold_stop: assert property (p_hold_stop) else $error("stopped counter moved");
  property p_flag_set;
    @(posedge mclk) disable iff (reset) t1_under |=> irq_flag_reg[1];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("underflow flag missing");
  property p_chain_noflag;
    @(posedge mclk) disable iff (reset) (chain && !irq_flag_reg[0]) |=> !irq_flag_reg[0];
  endproperty
  a_chain_noflag: assert property (p_chain_noflag) else $error("chained timer 0 flagged");
  property p_flag_clear;
    @(posedge mclk) disable iff (reset) (wr && hit_ifl && wn[0] && !t0_flag_set) |=> !irq_flag_reg[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear failed");
  property p_strobe_read0;
    @(posedge mclk) disable iff (reset) (rd && hit_t0c) |=> !prdata_reg[`DRDT_BIT_STB];
  endproperty
  a_strobe_read0: assert property (p_strobe_read0) else $error("strobe read nonzero");
  property p_latch;
    @(posedge mclk) disable iff (reset) (rd && hit_t0cl) |=> t0_hi_latch_reg == $past(t0_count_value[7:4]);
  endproperty
  a_latch: assert property (p_latch) else $error("high nibble not latched");
  property p_chain_dec;
    @(posedge mclk) disable iff (reset) (chain && t1_run_reg && !t1_strobe && !t0_under) |=> $stable(t1_count_value);
  endproperty
  a_chain_dec: assert property (p_chain_dec) else $error("chained timer 1 moved alone");
  property p_ien_upper;
    @(posedge mclk) disable iff (reset) (rd && hit_ien) |=> prdata_reg[3:2] == 2'b00;
  endproperty
  a_ien_upper: assert property (p_ien_upper) else $error("mask upper bits nonzero");
  property p_src_hold;
    @(posedge mclk) disable iff (reset)
      !t0_src_fall |=> $stable(p0_reg);
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("prescaler 0 moved without source edge");
  property p_ratio_wrap;
    @(posedge mclk) disable iff (reset)
      p0_hit |=> p0_reg == `DRDT_RST_BYTE;
  endproperty
  a_ratio_wrap: assert property (p_ratio_wrap) else $error("prescaler 0 did not wrap");
  property p_evt_only;
    @(posedge mclk) disable iff (reset)
      (mode_reg[`DRDT_BIT_EVT] && !evt_edge && !t0_strobe) |=> $stable(t0_count_value);
  endproperty
  a_evt_only: assert property (p_evt_only) else $error("event mode counted a prescaler tick");
  property p_evt_count;
    @(posedge mclk) disable iff (reset)
      (mode_reg[`DRDT_BIT_EVT] && evt_edge && t0_run_reg && !t0_strobe && t0_count_value != 8'h00)
        |=> t0_count_value == $past(t0_count_value) - 8'h01;
  endproperty
  a_evt_count: assert property (p_evt_count) else $error("event edge not counted");
  property p_t1_indep;
    @(posedge mclk) disable iff (reset)
      (!chain && t1_run_reg && p1_hit && !t1_strobe && t1_count_value != 8'h00)
        |=> t1_count_value == $past(t1_count_value) - 8'h01;
  endproperty
  a_t1_indep: assert property (p_t1_indep) else $error("timer 1 missed its own tick");
  property p_filter_step;
    @(posedge mclk) disable iff (reset)
      ($changed(filt_reg) && !$past(reset)) |-> ($past(tick_fall) && $past(ftick_reg) == 2'b01);
  endproperty
  a_filter_step: assert property (p_filter_step) else $error("filter changed off second tick");
  property p_filter_quiet;
    @(posedge mclk) disable iff (reset)
      (pin_now == filt_reg) |=> ftick_reg == 2'b00;
  endproperty
  a_filter_quiet: assert property (p_filter_quiet) else $error("filter tick count not cleared");
  property p_nofilter;
    @(posedge mclk) disable iff (reset)
      (mode_reg[`DRDT_BIT_EVT] && !mode_reg[`DRDT_BIT_NF] && !mode_reg[`DRDT_BIT_POL] && fall[3]
        && t0_run_reg && !t0_strobe && t0_count_value != 8'h00)
        |=> t0_count_value == $past(t0_count_value) - 8'h01;
  endproperty
  a_nofilter: assert property (p_nofilter) else $error("raw pin edge not counted");
  property p_timer_only;
    @(posedge mclk) disable iff (reset)
      (!mode_reg[`DRDT_BIT_EVT] && !p0_hit && !t0_strobe) |=> $stable(t0_count_value);
  endproperty
  a_timer_only: assert property (p_timer_only) else $error("timer mode counted a pin edge");
  property p_under_load;
    @(posedge mclk) disable iff (reset)
      t0_under |=> t0_count_value == $past(t0_reload_value);
  endproperty
  a_under_load: assert property (p_under_load) else $error("underflow did not reload");
  property p_ro_count;
    @(posedge mclk) disable iff (reset)
      (wr && hit_t0cl && !t0_dec) |=> $stable(t0_count_value);
  endproperty
  a_ro_count: assert property (p_ro_count) else $error("count write changed counter");
  property p_strobe_idle;
    @(posedge mclk) disable iff (reset)
      (wr && hit_t0c && !wn[`DRDT_BIT_STB] && !t0_dec) |=> $stable(t0_count_value);
  endproperty
  a_strobe_idle: assert property (p_strobe_idle) else $error("zero strobe changed counter");
  property p_irq_mask;
    @(posedge mclk) disable iff (reset)
      1'b1 |=> t0_irq_req == $past(irq_flag_reg[0] & irq_en_reg[0]);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("request not flag and mask");
  property p_t0_flag;
    @(posedge mclk) disable iff (reset)
      t0_flag_set |=> irq_flag_reg[0];
  endproperty
  a_t0_flag: assert property (p_t0_flag) else $error("timer 0 flag missing");
  property p_dec_run;
    @(posedge mclk) disable iff (reset)
      (t0_dec && !t0_strobe && t0_count_value != 8'h00) |=> t0_count_value == $past(t0_count_value) - 8'h01;
  endproperty
  a_dec_run: assert property (p_dec_run) else $error("counter did not decrement");
  property p_chain_step;
    @(posedge mclk) disable iff (reset)
      (chain && t0_under && t1_run_reg && !t1_strobe && t1_count_value != 8'h00)
        |=> t1_count_value == $past(t1_count_value) - 8'h01;
  endproperty
  a_chain_step: assert property (p_chain_step) else $error("chained timer 1 missed a step");
endmodule : drdt_timer
`default_nettype wire

// [verification/drdt_evt_src.sv]
/*
 Event source model that drives the timer's external count pin.
 Assumes the bench calls its task from a process clocked by mclk.
*/
`default_nettype none
module drdt_evt_src (
  input wire logic mclk,
  output logic event_count_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idles high, so the first edge is always a falling one
  initial event_count_pin = 1'b1;
  // Holds each level 8 cycles: longer than the pin synchroniser lag
  task automatic level(input logic v);
    @(posedge mclk);
    event_count_pin <= v;
    repeat (8) @(posedge mclk);
  endtask : level
endmodule : drdt_evt_src
`default_nettype wire

// [verification/drdt_timer_tb_top.sv]
/*
 Self-checking bench of the dual reload down timer over APB.
 Assumes the map header and the event source model are compiled first.
*/
`default_nettype none
`include "drdt_map.svh"
module drdt_timer_tb_top
  import drdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, slow, fast, tick, pin, irq0, irq1;
  logic [31:0] paddr, pwdata, prdata, d;
  logic [31:0] cyc = 32'h0;
  logic e;
  int failures = 0;
  int checks_done = 0;
  logic [15:0] regs [14] = '{`DRDT_IDX_MODE, `DRDT_IDX_CLKSRC, `DRDT_IDX_T0CTL, `DRDT_IDX_T1CTL,
    `DRDT_IDX_T0RLL, `DRDT_IDX_T0RLH, `DRDT_IDX_T1RLL, `DRDT_IDX_T1RLH, `DRDT_IDX_T0CNL,
    `DRDT_IDX_T0CNH, `DRDT_IDX_T1CNL, `DRDT_IDX_T1CNH, `DRDT_IDX_IEN, `DRDT_IDX_IFLG};
  logic [31:0] gaps [4] = '{32'h10, 32'h40, 32'h200, 32'h1000};
  always #5 mclk = ~mclk;
  // Sources locked to mclk so measured gaps are exact
  always @(posedge mclk) begin
    cyc <= cyc + 32'h1;
    slow <= cyc[2];
    fast <= cyc[1];
    tick <= cyc[5];
  end
  drdt_timer dut_u (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_oscillator_clock(slow), .fast_oscillator_clock(fast), .tick_2048hz(tick),
    .event_count_pin(pin), .t0_irq_req(irq0), .t1_irq_req(irq1));
  drdt_evt_src evt_u (.mclk(mclk), .event_count_pin(pin));
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic timeout;
    failures++;
    $display("Timeout at %0t", $time);
    stop_test();
  endtask : timeout
  // Register index times four gives the byte address
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [3:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {14'h0, idx, 2'b00};
    pwdata <= {28'h0, wd};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (n > 50) timeout();
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] idx, input logic [3:0] v);
    apb(1'b1, idx, v);
  endtask : wr
  task automatic rdc(input logic [15:0] idx, input logic [3:0] v);
    apb(1'b0, idx, 4'h0);
    chk(d, {28'h0, v});
  endtask : rdc
  task automatic wait_hi;
    int n;
    n = 0;
    while (irq1 !== 1'b1) begin
      @(posedge mclk);
      n++;
      if (n > 20000) timeout();
    end
  endtask : wait_hi
  task automatic clr;
    wr(`DRDT_IDX_IFLG, 4'h2);
    repeat (2) @(posedge mclk);
  endtask : clr
  // First two underflows after a change are discarded: prescaler phase is unknown
  task automatic gap(input logic [31:0] exp);
    logic [31:0] a;
    repeat (2) begin
      wait_hi();
      clr();
    end
    wait_hi();
    a = cyc;
    clr();
    wait_hi();
    chk(cyc - a, exp);
  endtask : gap
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    foreach (regs[i]) rdc(regs[i], 4'h0);
    apb(1'b0, 16'hFFD0, 4'h0);
    chk({31'h0, e}, 32'h1);
    wr(`DRDT_IDX_T0RLH, 4'h1);
    rdc(`DRDT_IDX_T0RLH, 4'h1);
    wr(`DRDT_IDX_T0CNL, 4'h7);
    wr(`DRDT_IDX_MODE, 4'h4);
    wr(`DRDT_IDX_T0CTL, 4'h2);
    rdc(`DRDT_IDX_T0CTL, 4'h0);
    rdc(`DRDT_IDX_T0CNL, 4'h0);
    rdc(`DRDT_IDX_T0CNH, 4'h1);
    evt_u.level(1'b0);
    evt_u.level(1'b1);
    rdc(`DRDT_IDX_T0CNL, 4'h0);
    wr(`DRDT_IDX_T0CTL, 4'h1);
    rdc(`DRDT_IDX_T0CNL, 4'h0);
    evt_u.level(1'b0);
    rdc(`DRDT_IDX_T0CNH, 4'h1);
    evt_u.level(1'b1);
    rdc(`DRDT_IDX_T0CNL, 4'hF);
    rdc(`DRDT_IDX_T0CNH, 4'h0);
    wr(`DRDT_IDX_MODE, 4'h5);
    evt_u.level(1'b0);
    rdc(`DRDT_IDX_T0CNL, 4'hF);
    evt_u.level(1'b1);
    rdc(`DRDT_IDX_T0CNL, 4'hE);
    wr(`DRDT_IDX_MODE, 4'h7);
    evt_u.level(1'b0);
    evt_u.level(1'b1);
    rdc(`DRDT_IDX_T0CNL, 4'hE);
    evt_u.level(1'b0);
    repeat (200) @(posedge mclk);
    evt_u.level(1'b1);
    repeat (200) @(posedge mclk);
    rdc(`DRDT_IDX_T0CNL, 4'hD);
    wr(`DRDT_IDX_MODE, 4'h5);
    wr(`DRDT_IDX_T0RLH, 4'h0);
    wr(`DRDT_IDX_T0RLL, 4'h1);
    wr(`DRDT_IDX_T0CTL, 4'h3);
    rdc(`DRDT_IDX_T0CNL, 4'h1);
    repeat (2) begin
      evt_u.level(1'b0);
      evt_u.level(1'b1);
    end
    rdc(`DRDT_IDX_T0CNL, 4'h1);
    rdc(`DRDT_IDX_IFLG, 4'h1);
    chk({31'h0, irq0}, 32'h0);
    wr(`DRDT_IDX_IEN, 4'h1);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq0}, 32'h1);
    wr(`DRDT_IDX_IFLG, 4'h0);
    rdc(`DRDT_IDX_IFLG, 4'h1);
    wr(`DRDT_IDX_IFLG, 4'h1);
    rdc(`DRDT_IDX_IFLG, 4'h0);
    wr(`DRDT_IDX_IEN, 4'hF);
    rdc(`DRDT_IDX_IEN, 4'h3);
    wr(`DRDT_IDX_T0CTL, 4'h0);
    wr(`DRDT_IDX_MODE, 4'h0);
    wr(`DRDT_IDX_IEN, 4'h2);
    wr(`DRDT_IDX_T1RLL, 4'h1);
    // Reload 1 gives two decrements per underflow; slow source is 8 cycles
    for (int k = 0; k < 4; k++) begin
      wr(`DRDT_IDX_T1CTL, {k[1:0], 2'b11});
      gap(gaps[k]);
    end
    wr(`DRDT_IDX_CLKSRC, 4'h2);
    wr(`DRDT_IDX_T1CTL, 4'h7);
    gap(32'h20);
    wr(`DRDT_IDX_T0RLL, 4'hF);
    wr(`DRDT_IDX_T0RLH, 4'hF);
    wr(`DRDT_IDX_IEN, 4'h3);
    wr(`DRDT_IDX_MODE, 4'h8);
    wr(`DRDT_IDX_CLKSRC, 4'h1);
    wr(`DRDT_IDX_T0CTL, 4'h3);
    wr(`DRDT_IDX_T1CTL, 4'h3);
    gap(32'h800);
    chk({31'h0, irq0}, 32'h0);
    stop_test();
  end
endmodule : drdt_timer_tb_top
`default_nettype wire
